// >>> common/mrt_pkg.sv
/*
 * Constants for the mailbox read-tracking and semaphore timeout block:
 * register offsets, field positions, reset values and timing counts.
 * Assumes a byte-wide local register port addressed by slave offset.
 */
package mrt_pkg;
    // ------------------------------------------------------------------
    // register offsets
    // ------------------------------------------------------------------
    localparam logic [7:0] OFS_READ_FLAGS_MID_HIGH = 8'h29;
    localparam logic [7:0] OFS_READ_FLAGS_MID_LOW  = 8'h2A;
    localparam logic [7:0] OFS_READ_FLAGS_LOW      = 8'h2B;
    localparam logic [7:0] OFS_SEM0_TIMEOUT        = 8'h2C;
    localparam logic [7:0] OFS_SEM1_TIMEOUT        = 8'h2D;

    // ------------------------------------------------------------------
    // timeout register fields
    // ------------------------------------------------------------------
    localparam int         BIT_EXPIRED     = 6;
    localparam int         BIT_ENABLE      = 5;
    localparam int         EXP_MSB         = 4;
    localparam int         EXP_W           = 5;
    localparam logic [7:0] RST_TIMEOUT_REG = 8'h00;
    localparam logic [7:0] RST_READ_FLAGS  = 8'h00;

    // ------------------------------------------------------------------
    // timing
    // ------------------------------------------------------------------
    localparam int BASE_TICKS = 128;   // oscillator periods at exponent 0
    localparam int CNT_W      = 40;    // holds 128 * 2^31
    localparam int NUM_MBOX   = 24;
endpackage

// >>> rtl/mrt_core.sv
/*
 * Mailbox read-tracking flags for mailboxes 23..0 and two semaphore
 * countdown timers with enable, expiry status and interrupt.
 * Assumes mailbox read and semaphore set/clear strobes come from logic
 * on clk; the peripheral clock enable arrives on clk's domain; the
 * oscillator tick arrives from another domain and is synchronised here.
 */
// Function
// - offset 29h flags track mailboxes 23..16
// - offset 2Ah flags track mailboxes 15..8
// - offset 2Bh flags track mailboxes 7..0
// - two identical timeout registers, one per semaphore
// - timers run on peripheral clock, halt when gated
// - semaphore set while clock stopped starts nothing
// - enabled semaphore set loads counter, then decrements
// - zero count raises interrupt and status bit 6
// - clearing semaphore clears the expiry status
// - clearing semaphore stops its counter
// - bit 5 enables timer and interrupt
// - length is 128 times two to exponent
// - local CPU reads the read-tracking flags
`timescale 1ns/10ps
module mrt_core
    import mrt_pkg::*;
#(
    parameter int NUM_SEM = 2
)
(
    input  wire logic                clk,
    input  wire logic                rst_n,
    input  wire logic                periph_clk_en,
    input  wire logic                osc_tick,
    input  wire logic                mbox_read,
    input  wire logic [4:0]          mbox_index,
    input  wire logic [NUM_SEM-1:0]  sem_set,
    input  wire logic [NUM_SEM-1:0]  sem_clear,
    input  wire logic                reg_wr,
    input  wire logic                reg_rd,
    input  wire logic [7:0]          reg_addr,
    input  wire logic [7:0]          reg_wdata,
    output logic [7:0]               reg_rdata,
    output logic [NUM_SEM-1:0]       timeout_irq
);
    import mrt_pkg::*;

    // the register map holds exactly two timeout registers
    if (NUM_SEM != 2)
    begin : g_num_sem_check
        $error("mrt_core serves exactly two semaphores");
    end

    // ------------------------------------------------------------------
    // oscillator tick synchroniser
    // ------------------------------------------------------------------
    logic tick_s1;
    logic tick_s2;
    logic tick_s3;
    logic tick_pulse;

    // edge detect looks only at the second and third stages
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            tick_s1 <= 1'b0;
            tick_s2 <= 1'b0;
            tick_s3 <= 1'b0;
        end
        else
        begin
            tick_s1 <= osc_tick;
            tick_s2 <= tick_s1;
            tick_s3 <= tick_s2;
        end
    end
    // gated peripheral clock freezes the timers
    assign tick_pulse = tick_s2 && !tick_s3 && periph_clk_en;

    // ------------------------------------------------------------------
    // read-tracking flags
    // ------------------------------------------------------------------
    logic [NUM_MBOX-1:0] read_flags;
    logic [NUM_MBOX-1:0] next_read_flags;
    logic [NUM_MBOX-1:0] clr_mask;
    logic [NUM_MBOX-1:0] set_mask;

    // set wins over a write-one clear in the same cycle
    always_comb
    begin
        clr_mask = '0;
        set_mask = '0;
        if (reg_wr && reg_addr == OFS_READ_FLAGS_MID_HIGH)
            clr_mask[23:16] = reg_wdata;
        if (reg_wr && reg_addr == OFS_READ_FLAGS_MID_LOW)
            clr_mask[15:8] = reg_wdata;
        if (reg_wr && reg_addr == OFS_READ_FLAGS_LOW)
            clr_mask[7:0] = reg_wdata;
        if (mbox_read && mbox_index < 5'(NUM_MBOX))
            set_mask[mbox_index] = 1'b1;
        next_read_flags = (read_flags & ~clr_mask) | set_mask;
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            read_flags <= {3{RST_READ_FLAGS}};
        else
            read_flags <= next_read_flags;
    end

    // ------------------------------------------------------------------
    // semaphore timers
    // ------------------------------------------------------------------
    logic             enable    [NUM_SEM];
    logic [EXP_W-1:0] exponent  [NUM_SEM];
    logic             expired   [NUM_SEM];
    logic             running   [NUM_SEM];
    logic [CNT_W-1:0] count     [NUM_SEM];
    logic             next_enable   [NUM_SEM];
    logic [EXP_W-1:0] next_exponent [NUM_SEM];
    logic             next_expired  [NUM_SEM];
    logic             next_running  [NUM_SEM];
    logic [CNT_W-1:0] next_count    [NUM_SEM];
    logic [7:0]       to_addr       [NUM_SEM];

    assign to_addr[0] = OFS_SEM0_TIMEOUT;
    assign to_addr[1] = OFS_SEM1_TIMEOUT;

    // clear beats set and expiry: clearing a semaphore stops its timer and clears its expiry status
    always_comb
    begin
        for (int i = 0; i < NUM_SEM; i++)
        begin
            next_enable[i]   = enable[i];
            next_exponent[i] = exponent[i];
            next_expired[i]  = expired[i];
            next_running[i]  = running[i];
            next_count[i]    = count[i];
            if (reg_wr && reg_addr == to_addr[i])
            begin
                next_enable[i]   = reg_wdata[BIT_ENABLE];
                next_exponent[i] = reg_wdata[EXP_MSB:0];
            end
            if (sem_clear[i])
            begin
                next_running[i] = 1'b0;
                next_expired[i] = 1'b0;
            end
            else if (sem_set[i] && enable[i] && periph_clk_en)
            begin
                next_running[i] = 1'b1;
                next_count[i]   = CNT_W'(BASE_TICKS) << exponent[i];
            end
            else if (running[i] && !enable[i])
                next_running[i] = 1'b0;
            else if (running[i] && tick_pulse)
            begin
                next_count[i] = count[i] - 1'b1;
                if (count[i] == CNT_W'(1))
                begin
                    next_running[i] = 1'b0;
                    next_expired[i] = 1'b1;
                end
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            for (int i = 0; i < NUM_SEM; i++)
            begin
                enable[i]   <= RST_TIMEOUT_REG[BIT_ENABLE];
                exponent[i] <= RST_TIMEOUT_REG[EXP_MSB:0];
                expired[i]  <= RST_TIMEOUT_REG[BIT_EXPIRED];
                running[i]  <= 1'b0;
                count[i]    <= '0;
            end
        end
        else
        begin
            for (int i = 0; i < NUM_SEM; i++)
            begin
                enable[i]   <= next_enable[i];
                exponent[i] <= next_exponent[i];
                expired[i]  <= next_expired[i];
                running[i]  <= next_running[i];
                count[i]    <= next_count[i];
            end
        end
    end

    // ------------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------------
    logic [7:0] next_rdata;

    // interrupt only while enabled; reserved bit 7 reads zero
    always_comb
    begin
        for (int i = 0; i < NUM_SEM; i++)
            timeout_irq[i] = expired[i] && enable[i];
        next_rdata = 8'h00;
        if (reg_rd)
        begin
            unique case (reg_addr)
                OFS_READ_FLAGS_MID_HIGH: next_rdata = read_flags[23:16];
                OFS_READ_FLAGS_MID_LOW:  next_rdata = read_flags[15:8];
                OFS_READ_FLAGS_LOW:      next_rdata = read_flags[7:0];
                OFS_SEM0_TIMEOUT:
                    next_rdata = {1'b0, expired[0], enable[0], exponent[0]};
                OFS_SEM1_TIMEOUT:
                    next_rdata = {1'b0, expired[1], enable[1], exponent[1]};
                default:                 next_rdata = 8'h00;
            endcase
        end
    end

    // read data registered: valid the cycle after reg_rd
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            reg_rdata <= 8'h00;
        else
            reg_rdata <= next_rdata;
    end

    // ------------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------------
    AST_READ_SETS: assert property (@(posedge clk) disable iff (!rst_n)
        mbox_read && mbox_index < 5'(NUM_MBOX) |=> read_flags[$past(mbox_index)])
        else $error("mailbox read did not set its flag");
    AST_FLAG_STICKS: assert property (@(posedge clk) disable iff (!rst_n)
        read_flags[0] && !(reg_wr && reg_addr == OFS_READ_FLAGS_LOW) |=> read_flags[0])
        else $error("read flag dropped without a clear");
    AST_LOAD: assert property (@(posedge clk) disable iff (!rst_n)
        sem_set[0] && !sem_clear[0] && enable[0] && periph_clk_en
        |=> running[0] && count[0] == (CNT_W'(BASE_TICKS) << $past(exponent[0])))
        else $error("timer not loaded on semaphore set");
    AST_STOPPED_SET: assert property (@(posedge clk) disable iff (!rst_n)
        !running[0] && sem_set[0] && !periph_clk_en |=> !running[0])
        else $error("timer started while peripheral clock stopped");
    AST_GATED: assert property (@(posedge clk) disable iff (!rst_n)
        running[0] && !periph_clk_en && !sem_set[0] && !reg_wr |=> $stable(count[0]))
        else $error("timer advanced with clock gated");
    AST_CLEAR: assert property (@(posedge clk) disable iff (!rst_n)
        sem_clear[1] |=> !running[1] && !expired[1] && !timeout_irq[1])
        else $error("clear left timer or status active");
    AST_EXPIRE: assert property (@(posedge clk) disable iff (!rst_n)
        running[0] && enable[0] && tick_pulse && count[0] == CNT_W'(1)
        && !sem_clear[0] && !sem_set[0] && !reg_wr
        |=> expired[0] && timeout_irq[0])
        else $error("expiry not flagged at zero");
    AST_DISABLED: assert property (@(posedge clk) disable iff (!rst_n)
        !enable[1] && !expired[1] |=> !expired[1] && !timeout_irq[1])
        else $error("interrupt while timeout disabled");
    AST_RESERVED: assert property (@(posedge clk) disable iff (!rst_n)
        reg_rd && reg_addr == OFS_SEM1_TIMEOUT |=> !reg_rdata[7])
        else $error("reserved bit read as one");

    COV_EXPIRY:  cover property (@(posedge clk) disable iff (!rst_n) $rose(expired[0]));
    COV_CLEAR:   cover property (@(posedge clk) disable iff (!rst_n) running[1] && sem_clear[1]);
    COV_READALL: cover property (@(posedge clk) disable iff (!rst_n) &read_flags);
endmodule

// >>> verification/mrt_host_model.sv
/*
 * Behavioural external host: reads mailboxes, sets semaphores, runs the
 * high-speed oscillator. Assumes the bench calls its tasks.
 */
`timescale 1ns/10ps
module mrt_host_model
(
    input  wire logic       clk,
    output logic            osc_tick,
    output logic            mbox_read,
    output logic [4:0]      mbox_index,
    output logic [1:0]      sem_set
);
    // -----------------------------------------------------------------
    // oscillator and host strobes
    // -----------------------------------------------------------------
    // free-running, 60 ns period; edges meet clk negedges every 150 ns but never clk posedges
    initial
    begin
        osc_tick = 1'b0;
        forever #30 osc_tick = ~osc_tick;
    end
    initial
    begin
        mbox_read  = 1'b0;
        mbox_index = 5'h00;
        sem_set    = 2'h0;
    end
    // one-cycle read pulse; index is inverted after so no stale value lingers
    task automatic read_mbox(input logic [4:0] idx);
        @(negedge clk);
        mbox_read  = 1'b1;
        mbox_index = idx;
        @(negedge clk);
        mbox_read  = 1'b0;
        mbox_index = ~idx;
    endtask
    // one-cycle semaphore set pulse
    task automatic set_sem(input logic [1:0] which);
        @(negedge clk);
        sem_set = which;
        @(negedge clk);
        sem_set = 2'h0;
    endtask
endmodule

// >>> verification/tb_top.sv
/*
 * Self-checking bench: read tracking flags, timeout fields and timers.
 * Assumes the host model drives mailbox reads, sets and the oscillator.
 */
`timescale 1ns/10ps
module tb_top;
    import mrt_pkg::*;
    logic        clk, rst_n, periph_clk_en, reg_wr, reg_rd, osc_tick, mbox_read;
    logic [1:0]  sem_set, sem_clear, timeout_irq;
    logic [4:0]  mbox_index;
    logic [7:0]  reg_addr, reg_wdata, reg_rdata, rnd, got;
    logic [23:0] flags;
    int          fails, tests_run, n;

    mrt_core i_mrt_core (.clk(clk), .rst_n(rst_n), .periph_clk_en(periph_clk_en),
        .osc_tick(osc_tick), .mbox_read(mbox_read), .mbox_index(mbox_index),
        .sem_set(sem_set), .sem_clear(sem_clear), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .timeout_irq(timeout_irq));
    mrt_host_model i_mrt_host_model (.clk(clk), .osc_tick(osc_tick),
        .mbox_read(mbox_read), .mbox_index(mbox_index), .sem_set(sem_set));

    // -----------------------------------------------------------------
    // clock, helpers and checks
    // -----------------------------------------------------------------
    initial
    begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    function automatic logic [7:0] lfsr(input logic [7:0] s);
        return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction
    function automatic int exp_len(input int e);
        return BASE_TICKS << e;
    endfunction
    task automatic test_done;
        $display("checks %0d mismatches %0d", tests_run, fails);
        if (fails == 0 && tests_run > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    task automatic check_byte(input logic [7:0] exp, input logic [7:0] act);
        tests_run++;
        if (act !== exp)
        begin
            fails++;
            $display("unexpected at %0t: expected %h got %h", $time, exp, act);
        end
    endtask
    // tick counts allow for the synchroniser lag of a few clk cycles
    task automatic check_range(input int lo, input int hi, input int act);
        tests_run++;
        if (act < lo || act > hi)
        begin
            fails++;
            $display("unexpected at %0t: expected %h..%h got %h", $time, lo, hi, act);
        end
    endtask
    task automatic reg_write(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk);
        reg_wr    = 1'b1;
        reg_addr  = a;
        reg_wdata = d;
        @(negedge clk);
        reg_wr = 1'b0;
    endtask
    // read data is registered, so it is sampled one cycle after the strobe
    task automatic reg_read(input logic [7:0] a, output logic [7:0] d);
        @(negedge clk);
        reg_rd   = 1'b1;
        reg_addr = a;
        @(negedge clk);
        reg_rd = 1'b0;
        d      = reg_rdata;
    endtask
    // every mapped offset and a few unmapped ones read zero after reset
    task automatic check_reset;
        for (int a = 8'h29; a <= 8'h30; a++)
        begin
            reg_read(8'(a), got);
            check_byte(8'h00, got);
        end
    endtask
    task automatic clear_sem(input int s);
        @(negedge clk);
        sem_clear = 2'(1 << s);
        @(negedge clk);
        sem_clear = 2'h0;
    endtask
    task automatic check_flags;
        reg_read(OFS_READ_FLAGS_MID_HIGH, got);
        check_byte(flags[23:16], got);
        reg_read(OFS_READ_FLAGS_MID_LOW, got);
        check_byte(flags[15:8], got);
        reg_read(OFS_READ_FLAGS_LOW, got);
        check_byte(flags[7:0], got);
    endtask
    // bounded wait on oscillator ticks; a wait that must end but does not stops the run
    task automatic ticks_to_irq(input int s, input int lim, input bit must, output int cnt);
        cnt = 0;
        while (timeout_irq[s] !== 1'b1 && cnt < lim)
        begin
            @(posedge osc_tick);
            cnt++;
        end
        if (must && cnt >= lim)
        begin
            fails++;
            test_done();
        end
    endtask

    initial
    begin
        rst_n         = 1'b0;
        periph_clk_en = 1'b1;
        sem_clear     = 2'h0;
        reg_wr        = 1'b0;
        reg_rd        = 1'b0;
        reg_addr      = 8'h00;
        reg_wdata     = 8'h00;
        fails         = 0;
        tests_run     = 0;
        rnd           = 8'h34;
        flags         = 24'h000000;
        repeat (6) @(negedge clk);
        rst_n = 1'b1;
        // reset values, unmapped offsets included
        check_reset();
        // random host reads plus both ends and an unmapped mailbox
        repeat (16)
        begin
            rnd = lfsr(rnd);
            i_mrt_host_model.read_mbox(rnd[4:0]);
            if (rnd[4:0] < 5'd24)
                flags[rnd[4:0]] = 1'b1;
        end
        i_mrt_host_model.read_mbox(5'd0);
        i_mrt_host_model.read_mbox(5'd23);
        i_mrt_host_model.read_mbox(5'd31);
        flags[0]  = 1'b1;
        flags[23] = 1'b1;
        check_flags();
        for (int r = 0; r < 3; r++)
        begin
            rnd = lfsr(rnd);
            reg_write(OFS_READ_FLAGS_MID_HIGH + 8'(r), rnd);
            flags[8*(2-r) +: 8] &= ~rnd;
        end
        check_flags();
        reg_write(OFS_SEM0_TIMEOUT, 8'hFF);
        reg_read(OFS_SEM0_TIMEOUT, got);
        check_byte(8'h3F, got);
        // short exponents keep each timeout well inside one frame
        for (int s = 0; s < 2; s++)
        begin
            reg_write(OFS_SEM0_TIMEOUT + 8'(s), 8'h20 | 8'(s));
            i_mrt_host_model.set_sem(2'(1 << s));
            ticks_to_irq(s, 400, 1'b1, n);
            check_range(exp_len(s) - 1, exp_len(s) + 3, n);
            reg_read(OFS_SEM0_TIMEOUT + 8'(s), got);
            check_byte(8'h60 | 8'(s), got);
            clear_sem(s);
            reg_read(OFS_SEM0_TIMEOUT + 8'(s), got);
            check_byte(8'h20 | 8'(s), got);
            check_byte(8'h00, {6'h00, timeout_irq});
        end
        // clear in mid-count must stop the timer
        i_mrt_host_model.set_sem(2'h1);
        repeat (60) @(posedge osc_tick);
        clear_sem(0);
        ticks_to_irq(0, 200, 1'b0, n);
        check_range(200, 200, n);
        // gated peripheral clock freezes the count, which resumes afterwards
        i_mrt_host_model.set_sem(2'h1);
        repeat (60) @(posedge osc_tick);
        @(negedge clk);
        periph_clk_en = 1'b0;
        ticks_to_irq(0, 200, 1'b0, n);
        check_range(200, 200, n);
        @(negedge clk);
        periph_clk_en = 1'b1;
        ticks_to_irq(0, 200, 1'b1, n);
        check_range(64, 73, n);
        clear_sem(0);
        // set while the clock is stopped starts nothing
        @(negedge clk);
        periph_clk_en = 1'b0;
        i_mrt_host_model.set_sem(2'h2);
        periph_clk_en = 1'b1;
        ticks_to_irq(1, 400, 1'b0, n);
        check_range(400, 400, n);
        // enable low: no timeout at all
        reg_write(OFS_SEM0_TIMEOUT, 8'h00);
        i_mrt_host_model.set_sem(2'h1);
        ticks_to_irq(0, 200, 1'b0, n);
        check_range(200, 200, n);
        // random register traffic, clears and gating while the host sets both semaphores
        fork
            for (int k = 0; k < 32; k++)
            begin
                @(negedge clk);
                rnd           = lfsr(rnd);
                periph_clk_en = rnd[0];
                reg_wr        = rnd[1];
                reg_rd        = rnd[2];
                sem_clear     = rnd[4:3];
                reg_addr      = 8'h29 + {5'h00, rnd[7:5]};
                reg_wdata     = lfsr(rnd);
            end
            repeat (8) i_mrt_host_model.set_sem(2'h3);
        join
        // mid-run reset wipes flags, timer fields and any running count
        @(negedge clk);
        periph_clk_en = 1'b1;
        reg_wr        = 1'b0;
        reg_rd        = 1'b0;
        sem_clear     = 2'h0;
        rst_n         = 1'b0;
        repeat (3) @(negedge clk);
        check_byte(8'h00, reg_rdata);
        check_byte(8'h00, {6'h00, timeout_irq});
        rst_n = 1'b1;
        check_reset();
        test_done();
    end
endmodule
